// ===== core/crc_pkg.sv
// Purpose: shared constants and types of the serial line check unit
// Assumes: 50 MHz system clock, 16-bit register port
// Notes: check values are kept in logical form, msb is bit 15
package crc_pkg;

    localparam int CLK_NS = 20;
    localparam int CLR_PULSE_NS = 100;
    localparam int CLR_PULSE_CYC = (CLR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CNT_W = 3;

    localparam int CRC_W = 16;
    localparam int SEND_CNT_W = 4;
    localparam logic [SEND_CNT_W-1:0] SEND_LAST = 4'hf;

    // input stage bit 0 is part of both polynomials
    localparam logic [CRC_W-1:0] TAPS_CRC16 = 16'h8005;
    localparam logic [CRC_W-1:0] TAPS_CCITT = 16'h1021;
    localparam logic [CRC_W-1:0] INIT_CRC16 = 16'h0000;
    localparam logic [CRC_W-1:0] INIT_CCITT = 16'hffff;
    localparam logic [CRC_W-1:0] RESIDUE_CRC16 = 16'h0000;
    // octal 016417
    localparam logic [CRC_W-1:0] RESIDUE_CCITT = 16'h1d0f;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_TXCRC = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_RXCRC = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 3'h5;

    localparam int CTRL_W = 3;
    localparam int CTRL_BITSTUFF = 0;
    localparam int CTRL_SOM = 1;
    localparam int CTRL_CRCEN = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    localparam int EV_W = 3;
    localparam int EV_GOOD = 0;
    localparam int EV_BAD = 1;
    localparam int EV_SENT = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    localparam int STATE_MATCH = 0;
    localparam int STATE_WINDOW = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } send_state_t;

endpackage

// ===== core/crc_shift_reg.sv
// Purpose: one 16-stage check register with selectable feedback taps
// Assumes: taps include the shared input stage bit 0
// Notes: with feedback off it only shifts, feeding zero at bit 0
`timescale 1ns/1ps
module crc_shift_reg #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic shiftEn,
    input wire logic feedbackEn,
    input wire logic dataIn,
    input wire logic [WIDTH-1:0] taps,
    input wire logic [WIDTH-1:0] initVal,
    // state
    output logic [WIDTH-1:0] value
);

    logic fb;
    logic [WIDTH-1:0] nextVal;

    // unused taps leave the previous stage untouched
    assign fb = feedbackEn & (dataIn ^ value[WIDTH-1]);
    assign nextVal = {value[WIDTH-2:0], 1'b0} ^ ({WIDTH{fb}} & taps);

    // all stages clocked and cleared together, clear first
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            value <= initVal;
        end
        else if (shiftEn)
        begin
            value <= nextVal;
        end
    end

endmodule

// ===== core/sync_line_crc_unit.sv
// Purpose: transmit check generator and receive check comparator
// Assumes: line clocks and receive data are pins, decoder signals are local
// Notes: line clocks are sampled, so they must be well below sys_clk/4
`timescale 1ns/1ps

module sync_line_crc_unit
    import crc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [crc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [crc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [crc_pkg::DATA_W-1:0] regRdData,
    output logic irq,
    // transmit path
    input wire logic txLineClk,
    input wire logic txDataBit,
    input wire logic crcClockEnable,
    input wire logic txEndOfData,
    output logic txBitStrobe,
    output logic crcSendWindow,
    output logic txLineBit,
    // receive path
    input wire logic rxLineClk,
    input wire logic rxLine,
    input wire logic rxEnable,
    input wire logic rxActive,
    input wire logic rxFrameEnd,
    output logic crcMatchFlag
);
    import crc_pkg::*;

    logic [CTRL_W-1:0] ctrl_q;
    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] events;
    logic bitstuffSelect;
    logic somClearRequest;
    logic crcEnable;
    logic [2:0] txClkSync_q;
    logic [2:0] rxClkSync_q;
    logic [1:0] rxLineSync_q;
    logic rxBitStrobe;
    logic rxBit;
    send_state_t state_q;
    logic [SEND_CNT_W-1:0] sendCnt_q;
    logic [PULSE_CNT_W-1:0] pulseCnt_q;
    logic windowFall;
    logic clearPulse;
    logic txClear;
    logic [CRC_W-1:0] taps;
    logic [CRC_W-1:0] initVal;
    logic [CRC_W-1:0] residue;
    logic [CRC_W-1:0] txCrc;
    logic [CRC_W-1:0] rxCrc;
    logic txShiftEn;
    logic txFeedbackEn;
    logic txLogicalBit;
    logic frameGood;

    assign bitstuffSelect = ctrl_q[CTRL_BITSTUFF];
    assign somClearRequest = ctrl_q[CTRL_SOM];
    assign crcEnable = ctrl_q[CTRL_CRCEN];

    // polynomial, cleared state and good residue follow the protocol
    assign taps = bitstuffSelect ? TAPS_CCITT : TAPS_CRC16;
    assign initVal = bitstuffSelect ? INIT_CCITT : INIT_CRC16;
    assign residue = bitstuffSelect ? RESIDUE_CCITT : RESIDUE_CRC16;

    // line clocks and receive data are asynchronous pins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            txClkSync_q <= 3'h0;
            rxClkSync_q <= 3'h0;
            rxLineSync_q <= 2'h0;
        end
        else
        begin
            txClkSync_q <= {txClkSync_q[1:0], txLineClk};
            rxClkSync_q <= {rxClkSync_q[1:0], rxLineClk};
            rxLineSync_q <= {rxLineSync_q[0], rxLine};
        end
    end

    // one strobe per bit time, taken from the rising line clock edge
    assign txBitStrobe = txClkSync_q[1] & ~txClkSync_q[2];
    assign rxBitStrobe = rxClkSync_q[1] & ~rxClkSync_q[2];
    // high level is logical zero in bitstuff mode
    assign rxBit = rxLineSync_q[1] ^ bitstuffSelect;

    // check character send window
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            sendCnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    sendCnt_q <= '0;
                    if (txEndOfData && crcEnable)
                    begin
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (txBitStrobe)
                    begin
                        sendCnt_q <= sendCnt_q + 4'h1;
                        if (sendCnt_q == SEND_LAST)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign crcSendWindow = (state_q == ST_SEND);
    assign windowFall = (state_q == ST_SEND) && txBitStrobe && (sendCnt_q == SEND_LAST);

    // clear pulse is a fixed width, started only by the window falling
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulseCnt_q <= '0;
        end
        else if (windowFall)
        begin
            pulseCnt_q <= PULSE_CNT_W'(CLR_PULSE_CYC);
        end
        else if (pulseCnt_q != '0)
        begin
            pulseCnt_q <= pulseCnt_q - 3'h1;
        end
    end

    assign clearPulse = (pulseCnt_q != '0);
    assign txClear = somClearRequest | clearPulse;

    // during the window the register only shifts its contents out
    assign txShiftEn = txBitStrobe & (crcClockEnable | crcSendWindow);
    assign txFeedbackEn = crcClockEnable & ~crcSendWindow;

    crc_shift_reg #(
        .WIDTH(CRC_W)
    ) txReg (
        .clk(sys_clk),
        .rst(rst),
        .clear(txClear),
        .shiftEn(txShiftEn),
        .feedbackEn(txFeedbackEn),
        .dataIn(txDataBit),
        .taps(taps),
        .initVal(initVal),
        .value(txCrc)
    );

    crc_shift_reg #(
        .WIDTH(CRC_W)
    ) rxReg (
        .clk(sys_clk),
        .rst(rst),
        .clear(~rxActive),
        .shiftEn(rxBitStrobe & rxEnable),
        .feedbackEn(1'b1),
        .dataIn(rxBit),
        .taps(taps),
        .initVal(initVal),
        .value(rxCrc)
    );

    // check character goes out complemented in bitstuff mode
    assign txLogicalBit = crcSendWindow ? (txCrc[CRC_W-1] ^ bitstuffSelect) : txDataBit;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            txLineBit <= 1'b0;
        end
        else if (txBitStrobe)
        begin
            txLineBit <= txLogicalBit ^ bitstuffSelect;
        end
    end

    // only a pass or fail flag; the processor handles recovery
    assign frameGood = (rxCrc == residue);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            crcMatchFlag <= 1'b0;
        end
        else if (rxFrameEnd)
        begin
            crcMatchFlag <= frameGood;
        end
    end

    // control register; software pulses the som bit itself
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            mask_q <= EV_RESET;
        end
        else if (regWr)
        begin
            if (regAddr == ADDR_CTRL)
            begin
                ctrl_q <= regWrData[CTRL_W-1:0];
            end
            if (regAddr == ADDR_MASK)
            begin
                mask_q <= regWrData[EV_W-1:0];
            end
        end
    end

    assign events[EV_GOOD] = rxFrameEnd & frameGood;
    assign events[EV_BAD] = rxFrameEnd & ~frameGood;
    assign events[EV_SENT] = windowFall;

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            status_q <= EV_RESET;
        end
        else if (regWr && regAddr == ADDR_STATUS)
        begin
            status_q <= (status_q & ~regWrData[EV_W-1:0]) | events;
        end
        else
        begin
            status_q <= status_q | events;
        end
    end

    assign irq = |(status_q & mask_q);

    // read data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk)
    begin
        if (rst || !regRd)
        begin
            regRdData <= '0;
        end
        else
        begin
            unique case (regAddr)
                ADDR_CTRL: regRdData <= DATA_W'(ctrl_q);
                ADDR_STATUS: regRdData <= DATA_W'(status_q);
                ADDR_MASK: regRdData <= DATA_W'(mask_q);
                ADDR_TXCRC: regRdData <= txCrc;
                ADDR_RXCRC: regRdData <= rxCrc;
                ADDR_STATE: regRdData <= DATA_W'({crcSendWindow, crcMatchFlag});
                default: regRdData <= '0;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence clearBurst;
        clearPulse [*5] ##1 !clearPulse;
    endsequence

    sequence lastSendBit;
        crcSendWindow && txBitStrobe && sendCnt_q == 4'hf;
    endsequence

    match_bitstuff_a: assert property (
        rxFrameEnd && bitstuffSelect |=> crcMatchFlag == ($past(rxCrc) == 16'h1d0f))
        else $error("bitstuff match flag wrong");

    match_char_a: assert property (
        rxFrameEnd && !bitstuffSelect |=> crcMatchFlag == ($past(rxCrc) == 16'h0000))
        else $error("char mode match flag wrong");

    fall_pulse_a: assert property (
        lastSendBit |=> clearBurst)
        else $error("clear pulse not five cycles after window fall");

    no_clear_a: assert property (
        crcSendWindow && !somClearRequest |-> !txClear)
        else $error("clear active while window high");

    window_len_a: assert property (
        lastSendBit |=> !crcSendWindow ##5 (txCrc == initVal || somClearRequest))
        else $error("window did not end with a cleared register");

    window_req_a: assert property (
        $rose(crcSendWindow) |-> $past(txEndOfData && crcEnable))
        else $error("window raised without request");

    hold_still_a: assert property (
        !txBitStrobe && !txClear |=> $stable(txCrc))
        else $error("transmit register moved without strobe");

    som_clear_a: assert property (
        somClearRequest && bitstuffSelect |=> txCrc == 16'hffff)
        else $error("som clear did not give all ones");

    zero_start_a: assert property (
        somClearRequest && !bitstuffSelect && $stable(bitstuffSelect) |=> txCrc == 16'h0000)
        else $error("char mode clear not all zeros");

    fcs_invert_a: assert property (
        crcSendWindow && txBitStrobe |=> txLineBit == $past(txCrc[15]))
        else $error("check bit polarity wrong on the line");

endmodule

// ===== tb/line_partner.sv
// Purpose: far side model, line clock and receive line level
// Assumes: bench raises run for one frame and sets rxBit per bit
// Notes: line clock stands still between frames
`timescale 1ns/1ps
module line_partner (
    // system clock
    input wire logic sys_clk,
    // frame control
    input wire logic run,
    input wire logic rxBit,
    input wire logic bitStuff,
    // line side
    output logic lineClk,
    output logic rxLineOut
);
    initial
    begin
        lineClk = 1'b0;
        rxLineOut = 1'b0;
    end
    // odd offset keeps line edges off the system clock edges
    always @(posedge run)
    begin
        #3;
        rxLineOut = rxBit ^ bitStuff;
        while (run)
        begin
            #80 lineClk = 1'b1;
            #80 lineClk = 1'b0;
            rxLineOut = rxBit ^ bitStuff;
        end
    end
    // idle line holds no value, it wiggles every cycle
    always @(posedge sys_clk)
    begin
        if (!run)
            rxLineOut <= ~rxLineOut;
    end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the line check unit
// Assumes: one 160 ns line clock feeds both transmit and receive
// Notes: data bits come from an lfsr with a fixed seed
`timescale 1ns/1ps
module tb_top;
    import crc_pkg::*;
    logic sys_clk, rst, regWr, regRd, irq, lineClk, txDataBit, crcClockEnable;
    logic txEndOfData, txBitStrobe, crcSendWindow, txLineBit, rxLine, rxEnable;
    logic rxActive, rxFrameEnd, crcMatchFlag, run, rxBit, mode;
    logic [2:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic [31:0] lfsr;
    int failCount, totalChecks, t;

    sync_line_crc_unit u_sync_line_crc_unit (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq), .txLineClk(lineClk), .txDataBit(txDataBit),
        .crcClockEnable(crcClockEnable), .txEndOfData(txEndOfData),
        .txBitStrobe(txBitStrobe), .crcSendWindow(crcSendWindow), .txLineBit(txLineBit),
        .rxLineClk(lineClk), .rxLine(rxLine), .rxEnable(rxEnable), .rxActive(rxActive),
        .rxFrameEnd(rxFrameEnd), .crcMatchFlag(crcMatchFlag));
    line_partner u_line_partner (.sys_clk(sys_clk), .run(run), .rxBit(rxBit),
        .bitStuff(mode), .lineClk(lineClk), .rxLineOut(rxLine));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b,
        input logic m);
        logic fb;
        fb = b ^ c[15];
        // taps 0,2,15 or 0,5,12
        return {c[14:0], 1'b0} ^ (fb ? (m ? 16'h1021 : 16'h8005) : 16'h0000);
    endfunction

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e)
        begin
            failCount++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic finalReport();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic regCheck(input logic [2:0] a, input logic [15:0] e, input string n);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk(n, e, regRdData);
    endtask

    // polling a cycle late would miss a one-cycle strobe, so poll every cycle
    task automatic waitStrobe();
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (txBitStrobe !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            failCount++;
            $display("FAIL strobe wait ran out");
            finalReport();
        end
    endtask

    task automatic runFrame(input logic m, input logic bad, input logic [2:0] mask);
        logic [15:0] txc, rxc, init;
        logic [63:0] bits, rxs;
        logic good;
        logic [2:0] stat;
        int n, k;
        init = m ? 16'hffff : 16'h0000;
        bits = '0;
        lfsr = lfsrNext(lfsr);
        n = 8 + int'(lfsr[3:0]);
        regWrite(ADDR_MASK, {13'h0000, mask});
        regWrite(ADDR_CTRL, {13'h0000, 2'b11, m});
        regCheck(ADDR_TXCRC, init, "txcrc at start");
        regWrite(ADDR_CTRL, {13'h0000, 2'b10, m});
        txc = init;
        rxc = init;
        for (k = 0; k < n; k++)
        begin
            lfsr = lfsrNext(lfsr);
            bits[k] = lfsr[0];
            txc = crcStep(txc, lfsr[0], m);
        end
        for (k = 0; k < 16; k++)
            bits[n + k] = txc[15 - k] ^ m;
        rxs = bits;
        rxs[lfsr[6:4]] = rxs[lfsr[6:4]] ^ bad;
        for (k = 0; k < n + 16; k++)
            rxc = crcStep(rxc, rxs[k], m);
        @(posedge sys_clk);
        mode <= m;
        rxActive <= 1'b1;
        rxEnable <= 1'b1;
        crcClockEnable <= 1'b1;
        txDataBit <= bits[0];
        rxBit <= rxs[0];
        run <= 1'b1;
        for (k = 0; k < n + 16; k++)
        begin
            waitStrobe();
            @(posedge sys_clk);
            txDataBit <= bits[k + 1];
            rxBit <= rxs[k + 1];
            if (k == n - 1)
            begin
                crcClockEnable <= 1'b0;
                txEndOfData <= 1'b1;
                @(posedge sys_clk);
                txEndOfData <= 1'b0;
            end
            #1;
            chk("window", 16'(k >= n - 1 && k != n + 15), crcSendWindow);
            // complemented, then inverted on the line
            if (k >= n)
                chk("line bit", 16'(txc[15 - k + n] ^ m ^ m), txLineBit);
            else
                chk("data bit", 16'(bits[k] ^ m), txLineBit);
        end
        run <= 1'b0;
        repeat (6) @(posedge sys_clk);
        regCheck(ADDR_TXCRC, init, "txcrc after send");
        good = (rxc == (m ? 16'h1d0f : 16'h0000));
        stat = {1'b1, ~good, good};
        @(posedge sys_clk);
        rxFrameEnd <= 1'b1;
        @(posedge sys_clk);
        rxFrameEnd <= 1'b0;
        #1;
        chk("match", 16'(good), crcMatchFlag);
        chk("irq", 16'(|(stat & mask)), irq);
        regCheck(ADDR_RXCRC, rxc, "rxcrc");
        regCheck(ADDR_STATUS, {13'h0000, stat}, "status");
        regCheck(ADDR_STATE, {15'h0000, good}, "state");
        regWrite(ADDR_STATUS, 16'h0007);
        regCheck(ADDR_STATUS, 16'h0000, "status cleared");
        chk("irq cleared", 16'h0000, irq);
        regCheck(3'h7, 16'h0000, "unmapped");
        rxActive <= 1'b0;
        regCheck(ADDR_RXCRC, init, "rxcrc idle");
        $display("test done mode %0d bad %0d bits %0d", m, bad, n);
    endtask

    initial
    begin
        rst = 1'b1;
        regAddr = 3'h0;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        txDataBit = 1'b0;
        crcClockEnable = 1'b0;
        txEndOfData = 1'b0;
        rxEnable = 1'b0;
        rxActive = 1'b0;
        rxFrameEnd = 1'b0;
        run = 1'b0;
        rxBit = 1'b0;
        mode = 1'b0;
        lfsr = 32'ha62b72fb;
        failCount = 0;
        totalChecks = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reset flag", 16'h0000, crcMatchFlag);
        for (t = 0; t < 6; t++)
        begin
            runFrame(t[0], t[1], (t < 2) ? 3'h7 : lfsr[9:7]);
            // a bad frame is simply followed by a clean new frame in the same mode
            if (t[1])
                runFrame(t[0], 1'b0, 3'h7);
        end
        // no window without the crc enable bit
        regWrite(ADDR_CTRL, 16'h0000);
        @(posedge sys_clk);
        txEndOfData <= 1'b1;
        @(posedge sys_clk);
        txEndOfData <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("window refused", 16'h0000, crcSendWindow);
        $display("test done refused window");
        finalReport();
    end
endmodule
